// ### rtl/balance_stop_and_voltage_guard.sv
`timescale 1ns/1ps
`include "guard_regs.svh"
module balance_stop_and_voltage_guard #(
  parameter int unsigned TICK_CYC   = `TICK_CYC,
  parameter int unsigned SETTLE_CYC = `SETTLE_CYC,
  parameter int unsigned BIST_CYC   = `BIST_CYC,
  parameter int unsigned SLOT_CYC   = `RR_SLOT_CYC
) (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  // cell balancing control
  input  wire logic                          balance_launch,
  input  wire logic [`NCH*`TIME_W-1:0]       per_cell_balance_time,
  input  wire logic [`VOLT_W-1:0]            cell_stop_voltage_level,
  input  wire logic                          fault_stop_enable,
  input  wire logic                          unmasked_fault,
  input  wire logic                          balance_pause,
  input  wire logic [1:0]                    post_balance_power_action,
  // remaining time readback
  input  wire logic [3:0]                    remaining_time_select,
  input  wire logic                          remaining_time_capture,
  // module drain
  input  wire logic [`MB_W-1:0]              module_drain_duration,
  input  wire logic [`VOLT_W-1:0]            module_stop_voltage_level,
  input  wire logic [`VOLT_W-1:0]            stack_voltage_sense,
  input  wire logic                          aux_adc_running,
  // voltage guard
  input  wire logic                          voltage_guard_launch,
  input  wire logic [1:0]                    voltage_guard_mode,
  input  wire logic [3:0]                    voltage_guard_channel_lock,
  input  wire logic [3:0]                    top_active_channel,
  input  wire logic [`VOLT_W-1:0]            overvoltage_level,
  input  wire logic [`VOLT_W-1:0]            undervoltage_level,
  input  wire logic [7:0]                    low_guard_mask_one,
  input  wire logic [7:0]                    low_guard_mask_two,
  input  wire logic [`NCH*`VOLT_W-1:0]       cell_voltage,
  // main converter
  input  wire logic                          adc_start,
  input  wire logic                          adc_valid,
  input  wire logic [`VOLT_W-1:0]            adc_data,
  // balancing status
  output logic [`NCH-1:0]                    cell_balance_on,
  output logic                               cell_balance_complete,
  output logic                               fault_abort_flag,
  output logic [`TIME_W-1:0]                 remaining_time_value,
  // drain status and pin
  output logic                               module_drain_active,
  output logic                               module_drain_complete,
  output logic                               drain_output_pin,
  output logic                               drain_pin_oe_n,
  // power action
  output logic                               power_mode_go,
  output logic [1:0]                         power_mode_sel,
  // guard status
  output logic                               guard_running,
  output logic [`NCH-1:0]                    ov_fault,
  output logic [`NCH-1:0]                    uv_fault,
  output logic [`VOLT_W-1:0]                 adc_result
);

  function automatic logic [`VOLT_W-1:0] volt_of(input logic [3:0] ch);
    volt_of = cell_voltage[ch*`VOLT_W +: `VOLT_W];
  endfunction

  guard_pkg::cb_state_t                cb_state_r;
  logic [`NCH-1:0][`TIME_W-1:0]        cb_timer_r;
  logic [`NCH-1:0]                     cb_act_r;
  logic [`NCH-1:0]                     cb_low_r;
  logic                                time_valid_r;
  logic                                cb_en_r;
  logic [31:0]                         tick_cnt_r;
  logic                                tick_r;
  logic [`MB_W-1:0]                    mb_cnt_r;
  logic                                mb_en_r;
  logic                                pwr_pend_r;
  logic [1:0]                          pwr_act_r;
  guard_pkg::guard_mode_t              g_mode_r;
  logic [`VOLT_W-1:0]                  g_ov_r;
  logic [`VOLT_W-1:0]                  g_uv_r;
  logic [`VOLT_W-1:0]                  g_stop_r;
  logic [3:0]                          g_top_r;
  logic [`NCH-1:0]                     g_mask_r;
  logic [3:0]                          g_lock_r;
  logic [3:0]                          scan_ch_r;
  logic [31:0]                         slot_cnt_r;
  logic [31:0]                         bist_cnt_r;
  logic [31:0]                         settle_cnt_r;
  logic                                all_zero;
  logic                                abort_now;
  logic                                slot_end;
  logic [3:0]                          eval_ch;
  logic [`VOLT_W-1:0]                  eval_v;

  assign all_zero  = (per_cell_balance_time == '0);
  assign abort_now = fault_stop_enable && unmasked_fault && !balance_pause;
  assign slot_end  = (slot_cnt_r == SLOT_CYC - 1);
  assign eval_ch   = (g_mode_r == guard_pkg::GM_SINGLE) ? g_lock_r
                                                        : scan_ch_r;
  assign eval_v    = volt_of(eval_ch);

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // balance time base
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
    end
    else
    begin
      tick_r     <= (tick_cnt_r == TICK_CYC - 1);
      tick_cnt_r <= (tick_cnt_r == TICK_CYC - 1) ? 32'h0 : tick_cnt_r + 32'h1;
    end

  // cell balancing timers and stop conditions
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      cb_state_r            <= guard_pkg::CB_IDLE;
      cb_timer_r            <= '0;
      cb_act_r              <= '0;
      cb_en_r               <= 1'b0;
      time_valid_r          <= 1'b0;
      cell_balance_complete <= 1'b0;
      fault_abort_flag      <= 1'b0;
      cell_balance_on       <= '0;
    end
    else if (balance_launch)
    begin
      cell_balance_complete <= 1'b0;
      fault_abort_flag      <= 1'b0;
      cell_balance_on       <= '0;
      for (int i = 0; i < `NCH; i++)
      begin
        cb_timer_r[i] <= per_cell_balance_time[i*`TIME_W +: `TIME_W]; // [R6]
        cb_act_r[i]   <= (per_cell_balance_time[i*`TIME_W +: `TIME_W] != 0);
      end
      cb_en_r      <= !all_zero;
      time_valid_r <= !all_zero;                                   // [R8]
      cb_state_r   <= all_zero ? guard_pkg::CB_IDLE                // [R4]
                               : guard_pkg::CB_RUN;
    end
    else
    begin
      unique case (cb_state_r)
        guard_pkg::CB_IDLE, guard_pkg::CB_STOP:
          cell_balance_on <= '0;
        guard_pkg::CB_RUN:
          if (abort_now)
          begin
            cb_act_r         <= '0;                                // [R3]
            cell_balance_on  <= '0;
            fault_abort_flag <= 1'b1;
            cb_state_r       <= guard_pkg::CB_STOP;
          end
          else if (cb_act_r == '0)
          begin
            cell_balance_complete <= 1'b1;                         // [R2] [R5]
            cell_balance_on       <= '0;
            cb_state_r            <= guard_pkg::CB_STOP;
          end
          else
          begin
            for (int i = 0; i < `NCH; i++)
              if (cb_act_r[i] && cb_low_r[i])
                cb_act_r[i] <= 1'b0;                               // [R1] [R9]
              else if (cb_act_r[i] && tick_r && !balance_pause)    // [R6]
              begin
                cb_timer_r[i] <= cb_timer_r[i] - 1'b1;
                if (cb_timer_r[i] == 1)
                  cb_act_r[i] <= 1'b0;                             // [R1]
              end
            cell_balance_on <= balance_pause ? '0 : cb_act_r & ~cb_low_r;
          end
      endcase
    end

  // remaining time capture
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      remaining_time_value <= `TIME_INVALID;
    else if (remaining_time_capture)                               // [R7]
      remaining_time_value <= time_valid_r ? cb_timer_r[remaining_time_select]
                                           : `TIME_INVALID;        // [R8]

  // module drain
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      mb_cnt_r              <= '0;
      mb_en_r               <= 1'b0;
      module_drain_active   <= 1'b0;
      module_drain_complete <= 1'b0;
      drain_output_pin      <= 1'b0;
      drain_pin_oe_n        <= 1'b1;
    end
    else if (balance_launch)
    begin
      mb_cnt_r              <= '0;
      mb_en_r               <= (module_drain_duration != 0);
      module_drain_active   <= (module_drain_duration != 0);       // [R11]
      drain_output_pin      <= (module_drain_duration != 0);
      drain_pin_oe_n        <= (module_drain_duration == 0);
      module_drain_complete <= 1'b0;                               // [R13]
    end
    else if (module_drain_active)
    begin
      if (fault_stop_enable && unmasked_fault)
      begin
        module_drain_active <= 1'b0;                               // [R13]
        drain_output_pin    <= 1'b0;
        drain_pin_oe_n      <= 1'b1;
      end
      else if ((tick_r && mb_cnt_r + 1'b1 == module_drain_duration) ||
               (aux_adc_running &&                                 // [R14]
                stack_voltage_sense < module_stop_voltage_level))
      begin
        module_drain_active   <= 1'b0;                             // [R12]
        module_drain_complete <= 1'b1;
        drain_output_pin      <= 1'b0;
        drain_pin_oe_n        <= 1'b1;
      end
      else if (tick_r)
        mb_cnt_r <= mb_cnt_r + 1'b1;
    end

  // post balance power action
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      pwr_pend_r     <= 1'b0;
      pwr_act_r      <= 2'h0;
      power_mode_go  <= 1'b0;
      power_mode_sel <= 2'h0;
    end
    else if (balance_launch)
    begin
      pwr_pend_r    <= (module_drain_duration != 0) || !all_zero;
      pwr_act_r     <= post_balance_power_action;
      power_mode_go <= 1'b0;
    end
    else if (pwr_pend_r && (!mb_en_r || module_drain_complete) &&
             (!cb_en_r || cell_balance_complete))
    begin
      pwr_pend_r     <= 1'b0;                                      // [R15]
      power_mode_go  <= 1'b1;
      power_mode_sel <= pwr_act_r;                                 // [R23]
    end
    else
      power_mode_go <= 1'b0;

  // guard launch, mode and scan
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      g_mode_r      <= guard_pkg::GM_STOP;
      g_ov_r        <= '0;
      g_uv_r        <= '0;
      g_stop_r      <= '0;
      g_top_r       <= 4'h0;
      g_mask_r      <= '0;
      g_lock_r      <= 4'h0;
      scan_ch_r     <= 4'h0;
      slot_cnt_r    <= 32'h0;
      bist_cnt_r    <= 32'h0;
      guard_running <= 1'b0;
    end
    else if (voltage_guard_launch)
    begin
      g_mode_r      <= guard_pkg::guard_mode_t'(voltage_guard_mode); // [R19]
      g_ov_r        <= overvoltage_level;                          // [R16]
      g_uv_r        <= undervoltage_level;
      g_stop_r      <= cell_stop_voltage_level;
      g_top_r       <= top_active_channel;
      g_mask_r      <= {low_guard_mask_two, low_guard_mask_one};   // [R17]
      g_lock_r      <= voltage_guard_channel_lock;
      scan_ch_r     <= 4'h0;
      slot_cnt_r    <= 32'h0;
      bist_cnt_r    <= 32'h0;
      guard_running <= (voltage_guard_mode != guard_pkg::GM_STOP);
    end
    else
    begin
      unique case (g_mode_r)
        guard_pkg::GM_STOP:
          guard_running <= 1'b0;
        guard_pkg::GM_BIST:
          if (bist_cnt_r == BIST_CYC - 1)
          begin
            g_mode_r      <= guard_pkg::GM_STOP;
            guard_running <= 1'b0;
          end
          else
            bist_cnt_r <= bist_cnt_r + 32'h1;
        guard_pkg::GM_RR, guard_pkg::GM_SINGLE:
        begin
          slot_cnt_r <= slot_end ? 32'h0 : slot_cnt_r + 32'h1;
          if (slot_end)
            scan_ch_r <= scan_ch_r + 4'h1;                         // [R20]
        end
      endcase
    end

  // window comparison per slot
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      ov_fault <= '0;
      uv_fault <= '0;
      cb_low_r <= '0;
    end
    else if (voltage_guard_launch)
    begin
      ov_fault <= '0;
      uv_fault <= '0;
      cb_low_r <= '0;
    end
    else if (slot_end && (g_mode_r == guard_pkg::GM_RR ||
                          g_mode_r == guard_pkg::GM_SINGLE))
    begin
      if (eval_ch <= g_top_r)                                      // [R16] [R20]
      begin
        if (eval_v > g_ov_r)
          ov_fault[eval_ch] <= 1'b1;                               // [R18]
        if (eval_v < g_uv_r && !g_mask_r[eval_ch])
          uv_fault[eval_ch] <= 1'b1;                               // [R17] [R18]
        if (g_mode_r == guard_pkg::GM_RR)
          cb_low_r[eval_ch] <= (g_stop_r != 0) && (eval_v < g_stop_r); // [R20]
      end
    end

  // converter result hold around self-test
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      adc_result   <= '0;
      settle_cnt_r <= 32'h0;
    end
    else if (g_mode_r == guard_pkg::GM_BIST)
    begin
      settle_cnt_r <= SETTLE_CYC;
      if (adc_start)
        adc_result <= `ADC_HELD;                                   // [R21]
    end
    else if (settle_cnt_r != 0)
      settle_cnt_r <= settle_cnt_r - 32'h1;                        // [R21]
    else if (adc_valid)
      adc_result <= adc_data;

  zero_launch_a: assert property (                                 // [R4]
    balance_launch && per_cell_balance_time == '0
    |=> !cell_balance_complete [*3])
    else $error("complete set after all-zero launch");
  invalid_time_a: assert property (                                // [R8]
    remaining_time_capture && !time_valid_r && !balance_launch
    |=> remaining_time_value == `TIME_INVALID)
    else $error("remaining time not invalid while stopped");
  abort_stop_a: assert property (                                  // [R3]
    cb_state_r == guard_pkg::CB_RUN && abort_now && !balance_launch
    |=> fault_abort_flag && cell_balance_on == '0 && !cell_balance_complete)
    else $error("fault stop did not abort balancing");
  complete_cause_a: assert property (                              // [R2]
    $rose(cell_balance_complete) |-> cb_act_r == '0 && !fault_abort_flag)
    else $error("complete set with channel still balancing");
  drain_pin_a: assert property (                                   // [R11]
    balance_launch && module_drain_duration != 0
    |=> module_drain_active && drain_output_pin && !drain_pin_oe_n)
    else $error("drain start did not take the pin");
  drain_no_aux_a: assert property (                                // [R14]
    module_drain_active && !aux_adc_running && !tick_r &&
    !unmasked_fault && !balance_launch |=> module_drain_active)
    else $error("drain stopped without timer");
  timer_hold_a: assert property (                                  // [R6]
    cb_state_r == guard_pkg::CB_RUN && balance_pause && !balance_launch
    |=> $stable(cb_timer_r))
    else $error("timers moved during pause");
  bist_result_a: assert property (                                 // [R21]
    g_mode_r == guard_pkg::GM_BIST && adc_start && !voltage_guard_launch
    |=> adc_result == `ADC_HELD)
    else $error("result not held at code during self-test");
  power_act_a: assert property (                                   // [R15]
    power_mode_go |-> !pwr_pend_r && power_mode_sel == pwr_act_r)
    else $error("power action out of order");

endmodule

// ### rtl/guard_pkg.sv
package guard_pkg;
  typedef enum logic [2:0] {
    CB_IDLE = 3'h1,
    CB_RUN  = 3'h2,
    CB_STOP = 3'h4
  } cb_state_t;
  typedef enum logic [1:0] {
    GM_STOP   = 2'h0,
    GM_RR     = 2'h1,
    GM_BIST   = 2'h2,
    GM_SINGLE = 2'h3
  } guard_mode_t;
endpackage

// ### rtl/guard_regs.svh
// Function
// R1 - each channel stops on own timer expiry or voltage under stop level
// R2 - balance complete set once every balancing channel stopped normally
// R3 - fault stop with unmasked fault halts all channels, sets abort flag; code ignores the fault while balance_pause is high
// R4 - launch with every time zero starts nothing, complete stays 0
// R5 - nonzero time but all cells under stop level: start, stop, complete
// R6 - sixteen countdown timers loaded at launch, frozen during pause
// R7 - host selects channel and captures its remaining time
// R8 - remaining time reads invalid code when balancing held stopped
// R9 - expired channel reads zero; voltage stop or abort reads time left
// R10 - host sets drain duration, stop level, runs aux converter, launches
// R11 - drain start drives drain pin as output and sets drain active
// R12 - drain ends complete on duration reached or stack under stop level
// R13 - zero duration relaunch or fault stop ends drain, complete stays 0
// R14 - drain never pauses; without aux converter only timer ends it
// R15 - power action applied after drain done and cell done if enabled
// R16 - common levels; top active channel field, lower channels active too
// R17 - two mask registers drop chosen channels from undervoltage test
// R18 - overvoltage above level, undervoltage below level, per channel
// R19 - guard launch with mode stop, round robin, self-test, single channel
// R20 - round robin loops all inputs, ignores inactive, tests stop level
// R21 - converter results 0x8000 or held in self-test, resume after settle
// R22 - host stops converter before guard self-test
// R23 - action code two means shutdown once balancing completes
`ifndef GUARD_REGS_SVH
`define GUARD_REGS_SVH
`define NCH 16
`define TIME_W 8
`define VOLT_W 16
`define MB_W 16
`define TIME_INVALID 8'hFF
`define ADC_HELD 16'h8000
`define ACT_SHUTDOWN 2'h2
`define CLK_MHZ 200
`define BAL_TICK_MS 1000
`define SETTLE_US 100
`define BIST_US 50
`define RR_SLOT_NS 500
`define TICK_CYC (`BAL_TICK_MS * `CLK_MHZ * 1000)
`define SETTLE_CYC (`SETTLE_US * `CLK_MHZ)
`define BIST_CYC (`BIST_US * `CLK_MHZ)
`define RR_SLOT_CYC ((`RR_SLOT_NS * `CLK_MHZ) / 1000)
`endif

// ### verif/balance_stop_and_voltage_guard_tb.sv
`timescale 1ns/1ps
`include "guard_regs.svh"
module balance_stop_and_voltage_guard_tb;
  logic                    core_clk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    balance_launch, remaining_time_capture;
  logic                    voltage_guard_launch, go_seen = 1'b0;
  logic [`NCH*`TIME_W-1:0] per_cell_balance_time = '0;
  logic [`NCH*`VOLT_W-1:0] cell_voltage = '0;
  logic [15:0]             cell_stop_voltage_level = '0, adc_data = '0;
  logic [15:0]             module_drain_duration = '0, stack_voltage_sense = '0;
  logic [15:0]             module_stop_voltage_level = '0, adc_result;
  logic [15:0]             overvoltage_level = '0, undervoltage_level = '0;
  logic [15:0]             cell_balance_on, ov_fault, uv_fault;
  logic [7:0]              low_guard_mask_one = '0, low_guard_mask_two = '0;
  logic [7:0]              remaining_time_value;
  logic [3:0]              remaining_time_select = '0, top_active_channel = '0;
  logic [3:0]              voltage_guard_channel_lock = '0;
  logic [1:0]              post_balance_power_action = '0, voltage_guard_mode = '0;
  logic [1:0]              power_mode_sel, sel_seen;
  logic                    fault_stop_enable = 1'b0, unmasked_fault = 1'b0;
  logic                    balance_pause = 1'b0, aux_adc_running = 1'b0;
  logic                    adc_start = 1'b0, adc_valid = 1'b0;
  logic                    cell_balance_complete, fault_abort_flag;
  logic                    module_drain_active, module_drain_complete;
  logic                    drain_output_pin, drain_pin_oe_n;
  logic                    power_mode_go, guard_running;
  logic [31:0]             seed = 32'hA1611DED;
  logic [7:0]              hold_v;
  int                      fail_count = 0, samples_checked = 0, i;

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (power_mode_go === 1'b1)
    begin
      go_seen <= 1'b1;
      sel_seen <= power_mode_sel;
    end

  host_model host (.core_clk, .balance_launch, .remaining_time_capture,
    .voltage_guard_launch);
  balance_stop_and_voltage_guard #(.TICK_CYC(10), .SETTLE_CYC(5),
    .BIST_CYC(8), .SLOT_CYC(2)) dut (.core_clk, .resetn, .balance_launch,
    .per_cell_balance_time, .cell_stop_voltage_level, .fault_stop_enable,
    .unmasked_fault, .balance_pause, .post_balance_power_action,
    .remaining_time_select, .remaining_time_capture, .module_drain_duration,
    .module_stop_voltage_level, .stack_voltage_sense, .aux_adc_running,
    .voltage_guard_launch, .voltage_guard_mode, .voltage_guard_channel_lock,
    .top_active_channel, .overvoltage_level, .undervoltage_level,
    .low_guard_mask_one, .low_guard_mask_two, .cell_voltage, .adc_start,
    .adc_valid, .adc_data, .cell_balance_on, .cell_balance_complete,
    .fault_abort_flag, .remaining_time_value, .module_drain_active,
    .module_drain_complete, .drain_output_pin, .drain_pin_oe_n,
    .power_mode_go, .power_mode_sel, .guard_running, .ov_fault, .uv_fault,
    .adc_result);

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // channels with a nonzero time are the ones expected to balance
  function automatic logic [15:0] busy_mask(input logic [127:0] t);
    for (int c = 0; c < 16; c++)
      busy_mask[c] = |t[8*c +: 8];
  endfunction

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cap(input logic [3:0] c);
    @(posedge core_clk);
    remaining_time_select <= c;
    host.strobe(1);
    #1;
  endtask

  task automatic wait_on(input int n);
    for (int k = 0; k < n && cell_balance_complete !== 1'b1; k++)
      @(posedge core_clk);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #100000;
    fail_count++;
    complete_run();
  end

  initial
  begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    cap(4'h3);
    chk("time no launch", 16'h00FF, remaining_time_value);
    host.strobe(0);
    repeat (30) @(posedge core_clk);
    chk("done zero times", 16'h0000, cell_balance_complete);
    cap(4'h0);
    chk("time zero launch", 16'h00FF, remaining_time_value);
    $display("test refusal done");
    // timer expiry with drain in parallel, aux converter off
    @(posedge core_clk);
    for (i = 0; i < 16; i++)
      per_cell_balance_time[8*i +: 8] <= (i == 0) ? 8'h03 : 8'(xs() % 4);
    module_drain_duration <= 16'h0003;
    module_stop_voltage_level <= 16'hF000;
    stack_voltage_sense <= 16'h1000;
    post_balance_power_action <= 2'h2;
    go_seen <= 1'b0;
    host.strobe(0);
    @(posedge core_clk);
    #1;
    chk("balance on", busy_mask(per_cell_balance_time), cell_balance_on);
    chk("drain active", 16'h0001, module_drain_active);
    chk("drain oe", 16'h0000, drain_pin_oe_n);
    chk("drain pin", 16'h0001, drain_output_pin);
    repeat (10) @(posedge core_clk);
    chk("drain no aux", 16'h0001, module_drain_active);
    wait_on(80);
    chk("cell done", 16'h0001, cell_balance_complete);
    repeat (40) @(posedge core_clk);
    chk("drain done", 16'h0001, module_drain_complete);
    chk("drain oe off", 16'h0001, drain_pin_oe_n);
    chk("power go", 16'h0001, go_seen);
    chk("power sel", 16'h0002, sel_seen);
    for (i = 0; i < 16; i++)
    begin
      cap(i[3:0]);
      chk("time expired", 16'h0000, remaining_time_value);
    end
    $display("test expiry done");
    // pause freezes timers and switches channels off
    @(posedge core_clk);
    per_cell_balance_time <= 128'h05 << 24;
    module_drain_duration <= 16'h0000;
    host.strobe(0);
    @(posedge core_clk);
    balance_pause <= 1'b1;
    repeat (3) @(posedge core_clk);
    cap(4'h3);
    hold_v = remaining_time_value;
    repeat (40) @(posedge core_clk);
    cap(4'h3);
    chk("time frozen", {8'h00, hold_v}, remaining_time_value);
    chk("paused off", 16'h0000, cell_balance_on);
    balance_pause <= 1'b0;
    $display("test pause done");
    // fault stop in mid balance
    @(posedge core_clk);
    per_cell_balance_time[7:0] <= 8'h32;
    module_drain_duration <= 16'h0064;
    fault_stop_enable <= 1'b1;
    host.strobe(0);
    repeat (20) @(posedge core_clk);
    unmasked_fault <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk("abort flag", 16'h0001, fault_abort_flag);
    chk("abort done", 16'h0000, cell_balance_complete);
    chk("abort on", 16'h0000, cell_balance_on);
    chk("drain abort", 16'h0000, {module_drain_active,
      module_drain_complete});
    cap(4'h0);
    chk("time left", 16'h0001, 16'(remaining_time_value != 8'h00));
    unmasked_fault <= 1'b0;
    fault_stop_enable <= 1'b0;
    $display("test fault done");
    // round robin and single channel guard runs
    @(posedge core_clk);
    for (i = 0; i < 16; i++)
      cell_voltage[16*i +: 16] <= (i == 1 || i == 5) ? 16'hA000 :
        (i == 2 || i == 3) ? 16'h1000 : 16'h3000 + 16'(xs() % 32'h5000);
    low_guard_mask_two <= 8'(xs());
    overvoltage_level <= 16'h9000;
    undervoltage_level <= 16'h2000;
    low_guard_mask_one <= 8'h04;
    top_active_channel <= 4'h3;
    voltage_guard_channel_lock <= 4'h1;
    for (i = 1; i < 4; i += 2)
    begin
      voltage_guard_mode <= i[1:0];
      host.strobe(2);
      #1;
      chk("guard run", 16'h0001, guard_running);
      repeat (80) @(posedge core_clk);
      #1;
      chk("ov fault", 16'h0002, ov_fault);
      chk("uv fault", i == 1 ? 16'h0008 : 16'h0000, uv_fault);
    end
    $display("test guard done");
    // stop level above every cell: starts then stops at once
    @(posedge core_clk);
    cell_voltage <= {16{16'h5000}};
    cell_stop_voltage_level <= 16'hFFFF;
    voltage_guard_mode <= 2'h1;
    host.strobe(2);
    repeat (40) @(posedge core_clk);
    per_cell_balance_time[7:0] <= 8'hC8;
    host.strobe(0);
    wait_on(100);
    chk("stop level done", 16'h0001, cell_balance_complete);
    cap(4'h0);
    chk("time kept", 16'h0001, 16'(remaining_time_value > 8'h00));
    $display("test stop level done");
    // self-test: converter results held at the fixed code
    @(posedge core_clk);
    voltage_guard_mode <= 2'h2;
    host.strobe(2);
    adc_start <= 1'b1;
    @(posedge core_clk);
    adc_start <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("bist adc", 16'h8000, adc_result);
    repeat (30) @(posedge core_clk);
    chk("bist ended", 16'h0000, guard_running);
    adc_data <= 16'(xs());
    adc_valid <= 1'b1;
    @(posedge core_clk);
    adc_valid <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("adc resumed", adc_data, adc_result);
    voltage_guard_mode <= 2'h0;
    host.strobe(2);
    #1;
    chk("guard stop", 16'h0000, guard_running);
    $display("test self-test done");
    // stack under drain stop level with aux converter running
    aux_adc_running <= 1'b1;
    host.strobe(0);
    repeat (3) @(posedge core_clk);
    chk("drain volt", 16'h0001, module_drain_complete);
    $display("test drain level done");
    complete_run();
  end
endmodule

// ### verif/host_model.sv
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic core_clk,
  // host strobes
  output logic      balance_launch,
  output logic      remaining_time_capture,
  output logic      voltage_guard_launch
);
  initial
  begin
    balance_launch = 1'b0;
    remaining_time_capture = 1'b0;
    voltage_guard_launch = 1'b0;
  end

  // one-cycle strobe: 0 balance, 1 capture, 2 guard
  task automatic strobe(input int k);
    @(posedge core_clk);
    case (k)
      0: balance_launch <= 1'b1;
      1: remaining_time_capture <= 1'b1;
      default: voltage_guard_launch <= 1'b1;
    endcase
    @(posedge core_clk);
    balance_launch <= 1'b0;
    remaining_time_capture <= 1'b0;
    voltage_guard_launch <= 1'b0;
  endtask
endmodule
